/* design/bml_fifo.sv */
`timescale 1ns/1ps
// ==========================================================================
// Byte FIFO between the boot sources and the image parser
module bml_fifo
  import bml_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic [AW:0]           level
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wp;
    logic [AW:0]                 rp;
  } bml_fifo_t;

  bml_fifo_t r_q;
  bml_fifo_t r_d;

  assign level     = r_q.wp - r_q.rp;
  assign in_ready  = level != (AW + 1)'(DEPTH);
  assign out_valid = level != '0;
  assign out_data  = r_q.mem[r_q.rp[AW-1:0]];

  always_comb begin
    r_d = r_q;
    if (in_valid && in_ready) begin
      r_d.mem[r_q.wp[AW-1:0]] = in_data;
      r_d.wp = r_q.wp + 1'b1;
    end
    if (out_valid && out_ready) begin
      r_d.rp = r_q.rp + 1'b1;
    end
    if (flush) begin
      r_d.wp = '0;
      r_d.rp = '0;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

endmodule : bml_fifo

/* design/bml_loader.sv */
`timescale 1ns/1ps
// Functional notes
// - Pins 00 run from 16-bit external memory; 01 boot from parallel flash.
// - Pins 10 boot from external SPI host; 11 from SPI slave memory.
// - Boot pins are captured into the reset configuration at every reset.
// - Bypass starts fetch at 0x2000_0000 with 16-bit packing, no loader.
// - Bypass and flash modes use 3 hold, 15 access, 4 setup cycles.
// - Parallel flash image is read through asynchronous bank 0.
// - On-chip flash is used when its enable is tied to bank 0 select.
// - SPI memory: select, read command, 0x00 address bytes until device detected.
// - After detection SPI memory data is shifted into instruction memory.
// - Host boot: device is SPI slave receiving the image bytes.
// - Host wait flag is high while the loader is busy; host pauses.
// - Host wait pin index comes from header flag bits 10:5.
// - Each block starts with a 10-byte header read from the source.
// - Header gives count and destination; blocks repeat until the final one.
// - Loaded images start execution at 0xFFA0_0000.
// - Software reset with skip bit set jumps straight to instruction memory.
module bml_loader
  import bml_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic [1:0]  boot_select_pins,
  input  wire logic        soft_reset_req,
  input  wire logic        skip_boot_sw,
  output logic [4:0]       rst_cfg_q,
  output logic             async_bank_zero_select_n,
  output logic             flash_rd_n,
  output logic [19:0]      flash_addr,
  input  wire logic [7:0]  flash_data,
  input  wire logic        onchip_flash_enable_input,
  output logic             onchip_flash_boot,
  output logic [3:0]       amem_setup_cyc,
  output logic [3:0]       amem_access_cyc,
  output logic [3:0]       amem_hold_cyc,
  output logic             spi_memory_select_output_n,
  output logic             spi_sck,
  output logic             spi_mosi,
  input  wire logic        spi_miso,
  input  wire logic        host_sck,
  input  wire logic        host_mosi,
  input  wire logic        host_ss_n,
  output logic             host_hold_off_flag,
  output logic [5:0]       hold_pin_sel,
  output logic             imem_we,
  output logic [31:0]      imem_addr,
  output logic [7:0]       imem_data,
  input  wire logic        imem_ready,
  output logic             core_release,
  output logic [31:0]      core_start_addr,
  output logic             fetch_pack16,
  output logic             load_error
);

  typedef struct packed {
    bml_state_t  st;
    logic [1:0]  settle;
    logic [4:0]  rst_cfg;
    logic        skip_req;
    logic [1:0]  bsel_m;
    logic [1:0]  bsel_s;
    logic [2:0]  hs_m;
    logic [2:0]  hs_s;
    logic        hs_sck_d;
    logic        miso_m;
    logic        miso_s;
    logic [7:0]  fd_m;
    logic [7:0]  fd_s;
    logic        fce_m;
    logic        fce_s;
    logic [3:0]  hdr_idx;
    logic [31:0] ld_addr;
    logic [31:0] ld_cnt;
    logic [15:0] ld_flag;
    logic        imem_we;
    logic [31:0] imem_addr;
    logic [7:0]  imem_data;
    bml_flash_t  fl;
    logic [3:0]  fl_cnt;
    logic [19:0] fl_addr;
    logic        bank0_n;
    logic        rd_n;
    logic [7:0]  fl_byte;
    logic        sm_busy;
    logic        sm_data;
    logic        sm_sel_n;
    logic        sm_sck;
    logic [1:0]  sm_div;
    logic [2:0]  sm_bit;
    logic [2:0]  sm_nadr;
    logic [7:0]  sm_tx;
    logic [7:0]  sm_rx;
    logic [2:0]  hs_bit;
    logic [7:0]  hs_sr;
    logic        hold;
    logic [5:0]  hold_sel;
    logic        push;
    logic [7:0]  push_data;
    logic        release_core;
    logic [31:0] start_addr;
    logic        pack16;
    logic        onchip;
    logic        err;
    logic [3:0]  amem_setup;
    logic [3:0]  amem_access;
    logic [3:0]  amem_hold;
  } bml_regs_t;

  bml_regs_t   r_q;
  bml_regs_t   r_d;
  logic        in_ready;
  logic        out_valid;
  logic        pop;
  logic [7:0]  out_data;
  logic [4:0]  level;
  logic [1:0]  mode;
  logic        loading;
  logic        blk_end;

  // ==========================================================================
  // Byte buffer
  bml_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .reset     (reset),
    .flush     (soft_reset_req),
    .in_valid  (r_q.push),
    .in_ready  (in_ready),
    .in_data   (r_q.push_data),
    .out_valid (out_valid),
    .out_ready (pop),
    .out_data  (out_data),
    .level     (level)
  );

  assign mode    = r_q.rst_cfg[1:0];
  assign loading = r_q.st == ST_LOAD;
  assign blk_end = (r_q.hdr_idx == HDR_BYTES) && (r_q.ld_cnt == '0);
  // Writes stall when instruction memory is busy
  assign pop     = loading && out_valid && imem_ready && !blk_end;

  // ==========================================================================
  // Next state
  always_comb begin
    r_d          = r_q;
    r_d.bsel_m   = boot_select_pins;
    r_d.bsel_s   = r_q.bsel_m;
    r_d.hs_m     = {host_ss_n, host_mosi, host_sck};
    r_d.hs_s     = r_q.hs_m;
    r_d.hs_sck_d = r_q.hs_s[0];
    r_d.miso_m   = spi_miso;
    r_d.miso_s   = r_q.miso_m;
    r_d.fd_m     = flash_data;
    r_d.fd_s     = r_q.fd_m;
    r_d.fce_m    = onchip_flash_enable_input;
    r_d.fce_s    = r_q.fce_m;
    r_d.imem_we  = 1'b0;
    r_d.push     = 1'b0;

    case (r_q.st)
      ST_SETTLE: begin
        if (r_q.settle != '0) begin
          r_d.settle = r_q.settle - 1'b1;
        end else begin
          r_d.rst_cfg = {r_q.skip_req, 2'b00, r_q.bsel_s};
          r_d.onchip  = (r_q.bsel_s == MODE_PFLASH) && r_q.fce_s;
          r_d.sm_tx   = SPI_READ_CMD;
          if (r_q.skip_req) begin
            r_d.st           = ST_RUN;
            r_d.release_core = 1'b1;
            r_d.start_addr   = L1_START_ADDR;
          end else if (r_q.bsel_s == MODE_BYPASS) begin
            r_d.st           = ST_RUN;
            r_d.release_core = 1'b1;
            r_d.start_addr   = BYPASS_START_ADDR;
            r_d.pack16       = 1'b1;
          end else begin
            r_d.st = ST_LOAD;
          end
        end
      end
      ST_LOAD: begin
        // Header then payload, block after block
        if (pop) begin
          if (r_q.hdr_idx != HDR_BYTES) begin
            if (r_q.hdr_idx < 4'(HDR_CNT_IDX)) begin
              r_d.ld_addr[{r_q.hdr_idx[1:0], 3'b000} +: 8] = out_data;
            end else if (r_q.hdr_idx < 4'(HDR_FLAG_IDX)) begin
              r_d.ld_cnt[{r_q.hdr_idx[1:0], 3'b000} +: 8] = out_data;
            end else begin
              r_d.ld_flag[{r_q.hdr_idx[0], 3'b000} +: 8] = out_data;
            end
            r_d.hdr_idx = r_q.hdr_idx + 1'b1;
          end else begin
            r_d.imem_we   = 1'b1;
            r_d.imem_addr = r_q.ld_addr;
            r_d.imem_data = out_data;
            r_d.ld_addr   = r_q.ld_addr + 1'b1;
            r_d.ld_cnt    = r_q.ld_cnt - 1'b1;
          end
        end else if (blk_end) begin
          if (r_q.ld_flag[FLAG_FINAL_BIT]) begin
            r_d.st = ST_COMMIT;
          end else begin
            r_d.hdr_idx = '0;
          end
        end
        if (r_q.hdr_idx == HDR_BYTES) begin
          r_d.hold_sel = r_q.ld_flag[FLAG_HOLD_LSB +: 6];
        end
      end
      ST_COMMIT: begin
        r_d.sm_sel_n = 1'b1;
        r_d.sm_sck   = 1'b0;
        if (!r_q.imem_we && imem_ready) begin
          r_d.st           = ST_RUN;
          r_d.release_core = 1'b1;
          r_d.start_addr   = L1_START_ADDR;
        end
      end
      ST_RUN: begin
        r_d.st = ST_RUN;
      end
      ST_FAIL: begin
        r_d.err      = 1'b1;
        r_d.sm_sel_n = 1'b1;
      end
      default: begin
        r_d.st = ST_FAIL;
      end
    endcase

    // ==========================================================================
    // Parallel flash reader on bank 0; a started read runs to its end even after loading stops, but a soft reset cancels it
    if (mode == MODE_PFLASH && (loading || r_q.fl != FL_IDLE)) begin
      case (r_q.fl)
        FL_IDLE: begin
          if (in_ready && !r_q.push) begin
            r_d.bank0_n = 1'b0;
            r_d.fl_cnt  = r_q.amem_setup - 1'b1;
            r_d.fl      = FL_SETUP;
          end
        end
        FL_SETUP: begin
          r_d.fl_cnt = r_q.fl_cnt - 1'b1;
          if (r_q.fl_cnt == '0) begin
            r_d.rd_n   = 1'b0;
            r_d.fl_cnt = r_q.amem_access - 1'b1;
            r_d.fl     = FL_ACC;
          end
        end
        FL_ACC: begin
          r_d.fl_cnt = r_q.fl_cnt - 1'b1;
          if (r_q.fl_cnt == '0) begin
            r_d.fl_byte = r_q.fd_s;
            r_d.rd_n    = 1'b1;
            r_d.fl_cnt  = r_q.amem_hold - 1'b1;
            r_d.fl      = FL_HOLD;
          end
        end
        FL_HOLD: begin
          r_d.fl_cnt = r_q.fl_cnt - 1'b1;
          if (r_q.fl_cnt == '0) begin
            r_d.bank0_n   = 1'b1;
            r_d.push      = 1'b1;
            r_d.push_data = r_q.fl_byte;
            r_d.fl_addr   = r_q.fl_addr + 1'b1;
            r_d.fl        = FL_IDLE;
          end
        end
        default: begin
          r_d.fl = FL_IDLE;
        end
      endcase
    end

    // ==========================================================================
    // SPI master for serial memory (clock idles low, sample on rising edge)
    if (loading && mode == MODE_SPI_MEM) begin
      r_d.sm_sel_n = 1'b0;
      if (!r_q.sm_busy) begin
        if (!r_q.sm_data || (in_ready && !r_q.push)) begin
          r_d.sm_busy = 1'b1;
          r_d.sm_bit  = '0;
          r_d.sm_div  = '0;
        end
      end else begin
        r_d.sm_div = r_q.sm_div + 1'b1;
        if (r_q.sm_div == SPI_HALF_PERIOD) begin
          r_d.sm_div = '0;
          r_d.sm_sck = !r_q.sm_sck;
          if (!r_q.sm_sck) begin
            r_d.sm_rx = {r_q.sm_rx[6:0], r_q.miso_s};
          end else begin
            r_d.sm_tx  = {r_q.sm_tx[6:0], 1'b0};
            r_d.sm_bit = r_q.sm_bit + 1'b1;
            if (r_q.sm_bit == 3'h7) begin
              r_d.sm_busy = 1'b0;
              r_d.sm_tx   = SPI_ADDR_FILL;
              r_d.sm_nadr = r_q.sm_nadr + 1'b1;
              if (r_q.sm_data) begin
                r_d.push      = 1'b1;
                r_d.push_data = r_q.sm_rx;
                r_d.sm_nadr   = r_q.sm_nadr;
              end else if (r_q.sm_nadr >= SPI_FIRST_PROBE && r_q.sm_rx != SPI_IDLE_BYTE) begin
                r_d.push      = 1'b1;
                r_d.push_data = r_q.sm_rx;
                r_d.sm_data   = 1'b1;
              end else if (r_q.sm_nadr == SPI_LAST_PROBE) begin
                r_d.st = ST_FAIL;
              end
            end
          end
        end
      end
    end

    // ==========================================================================
    // SPI slave for an external host
    r_d.hold = 1'b0;
    if (mode == MODE_SPI_HOST && r_q.st != ST_RUN) begin
      r_d.hold = !loading || level >= FIFO_HIGH_MARK;
    end
    if (loading && mode == MODE_SPI_HOST) begin
      if (r_q.hs_s[2]) begin
        r_d.hs_bit = '0;
      end else if (r_q.hs_s[0] && !r_q.hs_sck_d) begin
        r_d.hs_sr  = {r_q.hs_sr[6:0], r_q.hs_s[1]};
        r_d.hs_bit = r_q.hs_bit + 1'b1;
        if (r_q.hs_bit == 3'h7) begin
          if (in_ready && !r_q.push) begin
            r_d.push      = 1'b1;
            r_d.push_data = {r_q.hs_sr[6:0], r_q.hs_s[1]};
          end else begin
            r_d.st = ST_FAIL;
          end
        end
      end
    end

    // Software reset restarts the boot sequence
    if (soft_reset_req) begin
      r_d.st           = ST_SETTLE;
      r_d.settle       = PIN_SETTLE_CYC;
      r_d.skip_req     = skip_boot_sw;
      r_d.hdr_idx      = '0;
      r_d.ld_cnt       = '0;
      r_d.fl           = FL_IDLE;
      r_d.fl_addr      = '0;
      r_d.bank0_n      = 1'b1;
      r_d.rd_n         = 1'b1;
      r_d.sm_busy      = 1'b0;
      r_d.sm_data      = 1'b0;
      r_d.sm_sel_n     = 1'b1;
      r_d.sm_sck       = 1'b0;
      r_d.sm_nadr      = '0;
      r_d.hs_bit       = '0;
      r_d.push         = 1'b0;
      r_d.release_core = 1'b0;
      r_d.pack16       = 1'b0;
      r_d.err          = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      r_q             <= '0;
      r_q.st          <= ST_SETTLE;
      r_q.settle      <= PIN_SETTLE_CYC;
      r_q.fl          <= FL_IDLE;
      r_q.bank0_n     <= 1'b1;
      r_q.rd_n        <= 1'b1;
      r_q.sm_sel_n    <= 1'b1;
      r_q.hs_m        <= 3'h4;
      r_q.hs_s        <= 3'h4;
      r_q.amem_setup  <= AMEM_SETUP_CYC;
      r_q.amem_access <= AMEM_ACCESS_CYC;
      r_q.amem_hold   <= AMEM_HOLD_CYC;
    end else begin
      r_q <= r_d;
    end
  end

  assign rst_cfg_q                  = r_q.rst_cfg;
  assign async_bank_zero_select_n   = r_q.bank0_n;
  assign flash_rd_n                 = r_q.rd_n;
  assign flash_addr                 = r_q.fl_addr;
  assign onchip_flash_boot          = r_q.onchip;
  assign amem_setup_cyc             = r_q.amem_setup;
  assign amem_access_cyc            = r_q.amem_access;
  assign amem_hold_cyc              = r_q.amem_hold;
  assign spi_memory_select_output_n = r_q.sm_sel_n;
  assign spi_sck                    = r_q.sm_sck;
  assign spi_mosi                   = r_q.sm_tx[7];
  assign host_hold_off_flag         = r_q.hold;
  assign hold_pin_sel               = r_q.hold_sel;
  assign imem_we                    = r_q.imem_we;
  assign imem_addr                  = r_q.imem_addr;
  assign imem_data                  = r_q.imem_data;
  assign core_release               = r_q.release_core;
  assign core_start_addr            = r_q.start_addr;
  assign fetch_pack16               = r_q.pack16;
  assign load_error                 = r_q.err;

  // ==========================================================================
  // Checks
  sequence s_flash_read;
    ##4 $fell(r_q.rd_n) ##15 $rose(r_q.rd_n) ##3 $rose(r_q.bank0_n);
  endsequence

  property p_flash_cycle;
    @(posedge clock) disable iff (reset) $fell(r_q.bank0_n) |-> s_flash_read;
  endproperty
  a_flash_cycle: assert property (p_flash_cycle) else $error("flash cycle timing wrong");

  property p_bank0_read;
    @(posedge clock) disable iff (reset) !r_q.rd_n |-> !r_q.bank0_n && mode == MODE_PFLASH;
  endproperty
  a_bank0_read: assert property (p_bank0_read) else $error("read outside bank 0");

  property p_bypass;
    @(posedge clock) disable iff (reset)
      $rose(r_q.release_core) && mode == MODE_BYPASS && !r_q.rst_cfg[RSTCFG_SKIP_BIT]
      |-> r_q.start_addr == BYPASS_START_ADDR && r_q.pack16 && $past(r_q.st) == ST_SETTLE;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass start wrong");

  property p_l1_start;
    @(posedge clock) disable iff (reset)
      $rose(r_q.release_core) && (mode != MODE_BYPASS || r_q.rst_cfg[RSTCFG_SKIP_BIT])
      |-> r_q.start_addr == L1_START_ADDR && !r_q.pack16;
  endproperty
  a_l1_start: assert property (p_l1_start) else $error("loaded start address wrong");

  property p_capture;
    @(posedge clock) disable iff (reset)
      soft_reset_req ##1 !soft_reset_req [*5] |-> r_q.rst_cfg[1:0] == $past(r_q.bsel_s);
  endproperty
  a_capture: assert property (p_capture) else $error("boot pins not captured");

  sequence s_skip_req;
    soft_reset_req && skip_boot_sw ##1 !soft_reset_req [*5];
  endsequence

  property p_skip;
    @(posedge clock) disable iff (reset)
      s_skip_req |-> r_q.release_core && r_q.start_addr == L1_START_ADDR;
  endproperty
  a_skip: assert property (p_skip) else $error("skip boot did not jump");

  property p_header_first;
    @(posedge clock) disable iff (reset) r_q.imem_we |-> $past(r_q.hdr_idx) == HDR_BYTES;
  endproperty
  a_header_first: assert property (p_header_first) else $error("write before header");

  property p_commit;
    @(posedge clock) disable iff (reset)
      $rose(r_q.release_core) && mode != MODE_BYPASS && !r_q.rst_cfg[RSTCFG_SKIP_BIT]
      |-> $past(r_q.st) == ST_COMMIT && !$past(r_q.imem_we);
  endproperty
  a_commit: assert property (p_commit) else $error("core released early");

  property p_hold;
    @(posedge clock) disable iff (reset || soft_reset_req)
      mode == MODE_SPI_HOST && loading && level >= FIFO_HIGH_MARK |=> r_q.hold;
  endproperty
  a_hold: assert property (p_hold) else $error("host not held off");

  property p_spi_select;
    @(posedge clock) disable iff (reset)
      $rose(r_q.sm_sck) |-> !r_q.sm_sel_n && mode == MODE_SPI_MEM;
  endproperty
  a_spi_select: assert property (p_spi_select) else $error("spi clock without select");

endmodule : bml_loader

/* design/bml_pkg.sv */
// ==========================================================================
// Boot mode loader constants
package bml_pkg;

  localparam logic [1:0]  MODE_BYPASS       = 2'h0;
  localparam logic [1:0]  MODE_PFLASH       = 2'h1;
  localparam logic [1:0]  MODE_SPI_HOST     = 2'h2;
  localparam logic [1:0]  MODE_SPI_MEM      = 2'h3;

  localparam logic [31:0] BYPASS_START_ADDR = 32'h2000_0000;
  localparam logic [31:0] L1_START_ADDR     = 32'hFFA0_0000;

  // Slowest asynchronous memory timing, in clock cycles
  localparam logic [3:0]  AMEM_SETUP_CYC    = 4'h4;
  localparam logic [3:0]  AMEM_ACCESS_CYC   = 4'hF;
  localparam logic [3:0]  AMEM_HOLD_CYC     = 4'h3;

  // Block header: address (4), count (4), flag (2), little endian
  localparam logic [3:0]  HDR_BYTES         = 4'hA;
  localparam logic [3:0]  HDR_LAST_IDX      = 4'h9;
  localparam int          HDR_CNT_IDX       = 4;
  localparam int          HDR_FLAG_IDX      = 8;
  localparam int          FLAG_HOLD_LSB     = 5;
  localparam int          FLAG_FINAL_BIT    = 15;

  localparam logic [7:0]  SPI_READ_CMD      = 8'h03;
  localparam logic [7:0]  SPI_ADDR_FILL     = 8'h00;
  localparam logic [7:0]  SPI_IDLE_BYTE     = 8'hFF;
  localparam logic [2:0]  SPI_FIRST_PROBE   = 3'h2;
  localparam logic [2:0]  SPI_LAST_PROBE    = 3'h4;
  localparam logic [1:0]  SPI_HALF_PERIOD   = 2'h3;

  localparam int          FIFO_WIDTH        = 8;
  localparam int          FIFO_DEPTH        = 16;
  localparam logic [4:0]  FIFO_HIGH_MARK    = 5'h0C;

  localparam logic [1:0]  PIN_SETTLE_CYC    = 2'h3;
  localparam int          RSTCFG_SKIP_BIT   = 4;

  typedef enum logic [4:0] {
    ST_SETTLE = 5'h01,
    ST_LOAD   = 5'h02,
    ST_COMMIT = 5'h04,
    ST_RUN    = 5'h08,
    ST_FAIL   = 5'h10
  } bml_state_t;

  typedef enum logic [3:0] {
    FL_IDLE  = 4'h1,
    FL_SETUP = 4'h2,
    FL_ACC   = 4'h4,
    FL_HOLD  = 4'h8
  } bml_flash_t;

endpackage : bml_pkg

/* sim/bml_flash_model.sv */
`timescale 1ns/1ps
// ==========================================================================
// Byte-wide parallel flash seen through bank 0
module bml_flash_model (
  input  wire logic        async_bank_zero_select_n,
  input  wire logic        flash_rd_n,
  input  wire logic [19:0] flash_addr,
  output logic [7:0]       flash_data
);
  logic [7:0] mem [0:31];
  logic [7:0] last_q = 8'h00;
  // A released bus shows the inverse of the last byte, never a stale copy
  always_comb begin
    if (!async_bank_zero_select_n && !flash_rd_n) begin
      flash_data = mem[flash_addr[4:0]];
    end else begin
      flash_data = ~last_q;
    end
  end
  always @(posedge flash_rd_n) begin
    last_q <= mem[flash_addr[4:0]];
  end
endmodule : bml_flash_model

/* sim/tb_boot_mode_loader.sv */
`timescale 1ns/1ps
// ==========================================================================
// Boot loader bench
module tb_boot_mode_loader;
  import bml_pkg::*;
  typedef struct packed {logic [31:0] a; logic [7:0] d;} bml_wr_t;
  logic clock, reset, soft_reset_req, skip_boot_sw, onchip_flash_enable_input, imem_ready;
  logic spi_miso, host_sck, host_mosi, host_ss_n, async_bank_zero_select_n, flash_rd_n;
  logic onchip_flash_boot, spi_memory_select_output_n, spi_sck, spi_mosi, host_hold_off_flag;
  logic imem_we, core_release, fetch_pack16, load_error;
  logic [1:0]  boot_select_pins;
  logic [4:0]  rst_cfg_q;
  logic [19:0] flash_addr;
  logic [7:0]  flash_data, imem_data;
  logic [3:0]  amem_setup_cyc, amem_access_cyc, amem_hold_cyc;
  logic [5:0]  hold_pin_sel;
  logic [31:0] imem_addr, core_start_addr;
  logic [7:0]  d [0:2];
  logic [7:0]  img [0:22];
  bml_wr_t     exp_q [$];
  bml_wr_t     e;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          cyc = 0;

  bml_loader i_dut (.clock, .reset, .boot_select_pins, .soft_reset_req, .skip_boot_sw,
    .rst_cfg_q, .async_bank_zero_select_n, .flash_rd_n, .flash_addr, .flash_data,
    .onchip_flash_enable_input, .onchip_flash_boot, .amem_setup_cyc, .amem_access_cyc,
    .amem_hold_cyc, .spi_memory_select_output_n, .spi_sck, .spi_mosi, .spi_miso, .host_sck,
    .host_mosi, .host_ss_n, .host_hold_off_flag, .hold_pin_sel, .imem_we, .imem_addr,
    .imem_data, .imem_ready, .core_release, .core_start_addr, .fetch_pack16, .load_error);
  bml_flash_model i_flash (.async_bank_zero_select_n, .flash_rd_n, .flash_addr, .flash_data);

  // ==========================================================================
  // Checking and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  // Writes toward instruction memory are compared against the oldest note
  always @(posedge clock) begin
    if (!reset && imem_we === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(imem_addr, 32'hFFFF_FFFF);
      end else begin
        e = exp_q.pop_front();
        chk(imem_addr, e.a);
        chk({24'h0, imem_data}, {24'h0, e.d});
      end
    end
  end

  always @(posedge clock) begin
    if (cyc > 0) begin
      imem_ready <= ($urandom_range(0, 3) != 0);
    end
  end

  // ==========================================================================
  // Soft reset into a mode, then wait for release or error
  task automatic boot(input logic [1:0] m, input logic s, input int lim);
    int n;
    n = 0;
    boot_select_pins <= m;
    skip_boot_sw <= s;
    repeat (4) @(posedge clock);
    // A flash read still running must end before the soft reset
    while (async_bank_zero_select_n !== 1'b1) begin
      @(posedge clock);
    end
    soft_reset_req <= 1'b1;
    @(posedge clock);
    soft_reset_req <= 1'b0;
    repeat (5) @(posedge clock);
    while (core_release !== 1'b1 && load_error !== 1'b1 && n < lim) begin
      @(posedge clock);
      n++;
    end
    #1;
  endtask : boot

  // Expected writes of the test image, in order
  task automatic note_image;
    exp_q.push_back('{32'h10, d[0]});
    exp_q.push_back('{32'h11, d[1]});
    exp_q.push_back('{32'h20, d[2]});
  endtask : note_image

  // Host side of the serial link: waits out the hold flag, then sends one byte
  task automatic host_byte(input logic [7:0] b);
    while (host_hold_off_flag !== 1'b0) @(posedge clock);
    for (int i = 7; i >= 0; i--) begin
      host_mosi <= b[i];
      repeat (4) @(posedge clock);
      host_sck <= 1'b1;
      repeat (4) @(posedge clock);
      host_sck <= 1'b0;
    end
    repeat (4) @(posedge clock);
  endtask : host_byte

  initial begin
    void'($urandom(32'h46AD368E));
    {reset, imem_ready, spi_miso, host_ss_n} = 4'hF;
    {soft_reset_req, skip_boot_sw, onchip_flash_enable_input, host_sck, host_mosi} = 5'h00;
    boot_select_pins = MODE_BYPASS;
    foreach (d[k]) d[k] = 8'($urandom);
    img = '{8'h10, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, d[0], d[1],
            8'h20, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h60, 8'h80, d[2]};
    foreach (img[k]) i_flash.mem[k] = img[k];
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    repeat (8) @(posedge clock);
    #1;
    chk(core_start_addr, BYPASS_START_ADDR);
    chk({core_release, fetch_pack16, rst_cfg_q}, 7'h60);
    chk({amem_setup_cyc, amem_access_cyc, amem_hold_cyc}, 12'h4F3);
    boot(MODE_BYPASS, 1'b1, 50);
    chk(core_start_addr, L1_START_ADDR);
    chk({fetch_pack16, rst_cfg_q}, 6'h10);
    onchip_flash_enable_input <= 1'b1;
    note_image();
    boot(MODE_PFLASH, 1'b0, 8000);
    chk({core_release, fetch_pack16, onchip_flash_boot}, 3'h5);
    chk(core_start_addr, L1_START_ADDR);
    chk(32'(exp_q.size()), 32'h0);
    chk({26'h0, hold_pin_sel}, 32'h3);
    chk({amem_setup_cyc, amem_access_cyc, amem_hold_cyc}, 12'h4F3);
    boot(MODE_SPI_HOST, 1'b0, 10);
    chk({rst_cfg_q, host_hold_off_flag}, 6'h04);
    note_image();
    host_ss_n <= 1'b0;
    foreach (img[k]) host_byte(img[k]);
    host_ss_n <= 1'b1;
    repeat (20) @(posedge clock);
    #1;
    chk({load_error, core_release, host_hold_off_flag}, 3'h2);
    chk(32'(exp_q.size()), 32'h0);
    boot(MODE_SPI_MEM, 1'b0, 3000);
    chk({load_error, core_release, spi_memory_select_output_n, rst_cfg_q}, 8'hA3);
    wrap_up();
  end
endmodule : tb_boot_mode_loader
